// file: logic/cnr_defs.svh
// Constants of the command notch and resonance retune block
// Assumes a 125 MHz control clock and an APB register port
`ifndef CNR_DEFS_SVH
`define CNR_DEFS_SVH
// Register byte addresses
`define CNR_A_NOTCH_CFG  8'h00
`define CNR_A_NOTCH_ACT  8'h04
`define CNR_A_RETUNE_CFG 8'h08
`define CNR_A_DET_LEVEL  8'h0C
`define CNR_A_FILT1      8'h10
`define CNR_A_FILT2      8'h14
`define CNR_A_FILT3      8'h18
`define CNR_A_FILT4      8'h1C
`define CNR_A_FILT5      8'h20
`define CNR_A_STATUS     8'h24
// Field positions
`define CNR_F_FREQ_LSB   0
`define CNR_F_DEPTH_LSB  8
`define CNR_F_MODE_LSB   0
`define CNR_F_TUNE_LSB   2
`define CNR_F_F2SEL_LSB  4
`define CNR_F_F1EN_BIT   6
`define CNR_F_F2EN_BIT   7
`define CNR_F_WARN_BIT   16
`define CNR_F_NVDIRTY_BIT 17
`define CNR_F_PEND_BIT   18
`define CNR_F_VALID_BIT  12
// Reset values
`define CNR_RST_NOTCH    12'h000
`define CNR_RST_RTCFG    8'h00
`define CNR_RST_LEVEL    16'h0000
`define CNR_RST_FREQ     16'h0000
// Timing and thresholds
`define CNR_CLK_HZ       125000000
`define CNR_WARN_MS      5000
`define CNR_NV_S         300
`define CNR_FAST_MS      150
`define CNR_SLOW_MS      500
`define CNR_FAST_MIN_CHZ 18'd450
`define CNR_MIN_HZ       16'd100
`define CNR_BAND_LO      4'd7
`define CNR_BAND_HI      5'd13
`define CNR_BAND_DEN     4'd10
`endif

// file: logic/cnr_pkg.sv
// Types of the command notch and resonance retune block
// Used together with cnr_defs.svh
package cnr_pkg;
   typedef enum logic [1:0] {
      RT_OFF    = 2'h0,
      RT_CHANGE = 2'h1,
      RT_AUTO   = 2'h2,
      RT_RSVD   = 2'h3
   } cnr_mode_t;
   typedef enum logic {
      NS_IDLE = 1'b0,
      NS_WAIT = 1'b1
   } cnr_nstate_t;
   typedef struct packed {
      logic       enable;
      logic [17:0] freq_chz;
      logic [9:0] depth_cdb;
      logic [7:0] code;
      logic [3:0] depth_code;
   } cnr_notch_t;
   typedef struct packed {
      logic       valid;
      logic [15:0] level;
      logic [15:0] freq_hz;
   } cnr_osc_t;
endpackage

// file: logic/cnr_core.sv
// Command notch configuration and resonance retune control with APB registers
// Assumes all inputs come from logic on clock_in; no pin inputs
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "cnr_defs.svh"

module cnr_core
   import cnr_pkg::*;
#(
   parameter int unsigned  WARN_CYCLES = `CNR_WARN_MS * (`CNR_CLK_HZ / 1000),
   parameter longint unsigned NV_CYCLES = longint'(`CNR_NV_S) * `CNR_CLK_HZ,
   parameter int unsigned  FAST_CYCLES = `CNR_FAST_MS * (`CNR_CLK_HZ / 1000),
   parameter int unsigned  SLOW_CYCLES = `CNR_SLOW_MS * (`CNR_CLK_HZ / 1000)
) (
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [31:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Servo state and oscillation detector
   input  wire logic        motion_busy_in,
   input  wire cnr_osc_t    osc_in,
   // Filter settings towards the servo loop
   output cnr_notch_t       notch_out,
   output logic [4:0][15:0] res_freq_out,
   output logic [1:0]       res_en_out,
   output logic             retune_warning_out,
   output logic [15:0]      retune_count_out,
   // Non-volatile commit request
   output logic             nv_commit_out,
   output logic [15:0]      nv_freq1_out,
   output logic [15:0]      nv_freq2_out
);

   function automatic logic [17:0] freq_chz(input logic [7:0] c);
      case (c)
         8'h01: freq_chz = 18'd200000; 8'h02: freq_chz = 18'd100000;
         8'h03: freq_chz = 18'd66600;  8'h04: freq_chz = 18'd50000;
         8'h06: freq_chz = 18'd40000;  8'h07: freq_chz = 18'd33300;
         8'h08: freq_chz = 18'd28500;  8'h09: freq_chz = 18'd25000;
         8'h0A: freq_chz = 18'd22200;  8'h0B: freq_chz = 18'd20000;
         8'h0C: freq_chz = 18'd18100;  8'h0D: freq_chz = 18'd16600;
         8'h0F: freq_chz = 18'd15300;  8'h10: freq_chz = 18'd14200;
         8'h11: freq_chz = 18'd13300;  8'h12: freq_chz = 18'd12500;
         8'h13: freq_chz = 18'd11700;  8'h14: freq_chz = 18'd11100;
         8'h15: freq_chz = 18'd10500;  8'h16: freq_chz = 18'd10000;
         8'h17: freq_chz = 18'd9500;   8'h19: freq_chz = 18'd9000;
         8'h1A: freq_chz = 18'd8600;   8'h1B: freq_chz = 18'd8300;
         8'h1C: freq_chz = 18'd8000;   8'h1D: freq_chz = 18'd7600;
         8'h1E: freq_chz = 18'd7400;   8'h1F: freq_chz = 18'd7100;
         8'h21: freq_chz = 18'd6600;   8'h22: freq_chz = 18'd6200;
         8'h23: freq_chz = 18'd5800;   8'h24: freq_chz = 18'd5500;
         8'h25: freq_chz = 18'd5200;   8'h26: freq_chz = 18'd5000;
         8'h27: freq_chz = 18'd4700;   8'h29: freq_chz = 18'd4500;
         8'h2A: freq_chz = 18'd4300;   8'h2B: freq_chz = 18'd4100;
         8'h2C: freq_chz = 18'd4000;   8'h2D: freq_chz = 18'd3800;
         8'h2E: freq_chz = 18'd3700;   8'h2F: freq_chz = 18'd3500;
         8'h30: freq_chz = 18'd3450;   8'h31: freq_chz = 18'd3330;
         8'h32: freq_chz = 18'd3130;   8'h33: freq_chz = 18'd2940;
         8'h34: freq_chz = 18'd2780;   8'h35: freq_chz = 18'd2630;
         8'h36: freq_chz = 18'd2500;   8'h38: freq_chz = 18'd2380;
         8'h39: freq_chz = 18'd2270;   8'h3B: freq_chz = 18'd2080;
         8'h3C: freq_chz = 18'd2000;   8'h3D: freq_chz = 18'd1920;
         8'h3E: freq_chz = 18'd1850;   8'h3F: freq_chz = 18'd1790;
         8'h40: freq_chz = 18'd1720;   8'h41: freq_chz = 18'd1670;
         8'h42: freq_chz = 18'd1560;   8'h43: freq_chz = 18'd1470;
         8'h44: freq_chz = 18'd1390;   8'h45: freq_chz = 18'd1320;
         8'h46: freq_chz = 18'd1250;   8'h48: freq_chz = 18'd1190;
         8'h49: freq_chz = 18'd1140;   8'h4A: freq_chz = 18'd1090;
         8'h4B: freq_chz = 18'd1040;   8'h4C: freq_chz = 18'd1000;
         8'h4D: freq_chz = 18'd960;    8'h4E: freq_chz = 18'd930;
         8'h4F: freq_chz = 18'd890;    8'h50: freq_chz = 18'd860;
         8'h51: freq_chz = 18'd830;    8'h52: freq_chz = 18'd780;
         8'h53: freq_chz = 18'd740;    8'h54: freq_chz = 18'd690;
         8'h55: freq_chz = 18'd660;    8'h56: freq_chz = 18'd630;
         8'h58: freq_chz = 18'd600;    8'h59: freq_chz = 18'd570;
         8'h5C: freq_chz = 18'd500;    8'h5D: freq_chz = 18'd480;
         8'h5E: freq_chz = 18'd460;    8'h5F: freq_chz = 18'd450;
         8'h60: freq_chz = 18'd431;    8'h61: freq_chz = 18'd417;
         8'h62: freq_chz = 18'd391;    8'h63: freq_chz = 18'd368;
         8'h64: freq_chz = 18'd347;    8'h65: freq_chz = 18'd329;
         8'h66: freq_chz = 18'd313;    8'h68: freq_chz = 18'd298;
         8'h69: freq_chz = 18'd284;    8'h6A: freq_chz = 18'd272;
         8'h6B: freq_chz = 18'd260;    8'h6C: freq_chz = 18'd250;
         8'h6D: freq_chz = 18'd240;    8'h6E: freq_chz = 18'd231;
         8'h6F: freq_chz = 18'd223;    8'h71: freq_chz = 18'd208;
         8'h72: freq_chz = 18'd195;    8'h73: freq_chz = 18'd184;
         8'h74: freq_chz = 18'd174;    8'h75: freq_chz = 18'd164;
         8'h76: freq_chz = 18'd156;    8'h78: freq_chz = 18'd149;
         8'h79: freq_chz = 18'd142;    8'h7A: freq_chz = 18'd136;
         8'h7B: freq_chz = 18'd130;    8'h7C: freq_chz = 18'd125;
         8'h7D: freq_chz = 18'd120;    8'h7E: freq_chz = 18'd116;
         8'h7F: freq_chz = 18'd112;
         default: freq_chz = 18'd0;
      endcase
   endfunction

   // Depth magnitude in tenths of a dB
   function automatic logic [9:0] depth_cdb(input logic [3:0] d);
      unique case (d)
         4'h0: depth_cdb = 10'd400; 4'h1: depth_cdb = 10'd241;
         4'h2: depth_cdb = 10'd181; 4'h3: depth_cdb = 10'd145;
         4'h4: depth_cdb = 10'd120; 4'h5: depth_cdb = 10'd101;
         4'h6: depth_cdb = 10'd85;  4'h7: depth_cdb = 10'd72;
         4'h8: depth_cdb = 10'd60;  4'h9: depth_cdb = 10'd50;
         4'hA: depth_cdb = 10'd41;  4'hB: depth_cdb = 10'd33;
         4'hC: depth_cdb = 10'd25;  4'hD: depth_cdb = 10'd18;
         4'hE: depth_cdb = 10'd12;  4'hF: depth_cdb = 10'd6;
      endcase
   endfunction

   // Within plus or minus 30 percent of a setting
   function automatic logic in_band(input logic [15:0] det, input logic [15:0] set);
      logic [20:0] d10;
      logic [20:0] lo;
      logic [20:0] hi;
      d10 = 21'(det) * 21'(`CNR_BAND_DEN);
      lo  = 21'(set) * 21'(`CNR_BAND_LO);
      hi  = 21'(set) * 21'(`CNR_BAND_HI);
      in_band = (d10 >= lo) && (d10 <= hi);
   endfunction

   function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
      abs_diff = (a >= b) ? a - b : b - a;
   endfunction

   logic [11:0]     notch_cfg_r;
   logic            notch_pend_r;
   cnr_nstate_t     nstate_r;
   logic [31:0]     wait_cnt_r;
   cnr_notch_t      notch_r;
   logic [7:0]      rt_cfg_r;
   logic [15:0]     det_level_r;
   logic [4:0][15:0] freq_r;
   logic [31:0]     warn_cnt_r;
   logic            warn_r;
   logic [15:0]     rt_count_r;
   logic [39:0]     nv_timer_r;
   logic            nv_dirty_r;
   logic            nv_commit_r;
   logic [15:0]     nv_f1_r;
   logic [15:0]     nv_f2_r;
   logic [31:0]     prdata_r;
   logic            pslverr_r;

   logic            apb_setup;
   logic            apb_wr;
   logic            hit;
   logic [31:0]     rd_val;
   logic [7:0]      wa;
   cnr_mode_t       mode;
   logic [15:0]     det;
   logic            elig1;
   logic            elig2;
   logic            pick1;
   logic            fire;
   logic            nv_due;
   logic [31:0]     wait_lim;
   logic            apply;

   assign apb_setup = psel_in & ~penable_in;
   assign apb_wr    = psel_in & penable_in & pwrite_in;
   assign wa        = paddr_in[7:0];

   // Register read decode
   always_comb begin
      hit    = (paddr_in[31:8] == 24'h000000) && (paddr_in[1:0] == 2'h0)
               && (wa <= `CNR_A_STATUS);
      rd_val = 32'h00000000;
      case (wa)
         `CNR_A_NOTCH_CFG:  rd_val = 32'(notch_cfg_r);
         `CNR_A_NOTCH_ACT:  rd_val = 32'({notch_r.enable, notch_r.depth_code,
                                           notch_r.code});
         `CNR_A_RETUNE_CFG: rd_val = 32'(rt_cfg_r);
         `CNR_A_DET_LEVEL:  rd_val = 32'(det_level_r);
         `CNR_A_FILT1:      rd_val = 32'(freq_r[0]);
         `CNR_A_FILT2:      rd_val = 32'(freq_r[1]);
         `CNR_A_FILT3:      rd_val = 32'(freq_r[2]);
         `CNR_A_FILT4:      rd_val = 32'(freq_r[3]);
         `CNR_A_FILT5:      rd_val = 32'(freq_r[4]);
         `CNR_A_STATUS:     rd_val = {13'h0000, notch_pend_r, nv_dirty_r, warn_r, rt_count_r};
         default:           rd_val = 32'h00000000;
      endcase
   end

   // Read data and error are captured in the setup cycle
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else if (apb_setup) begin
         prdata_r  <= hit ? rd_val : 32'h00000000;
         pslverr_r <= ~hit;
      end
   end

   // Retune eligibility and trigger
   always_comb begin
      mode  = cnr_mode_t'(rt_cfg_r[`CNR_F_MODE_LSB +: 2]);
      det   = osc_in.freq_hz;
      elig1 = rt_cfg_r[`CNR_F_F1EN_BIT] & in_band(det, freq_r[0]);
      elig2 = rt_cfg_r[`CNR_F_F2EN_BIT] & in_band(det, freq_r[1]);
      if (mode == RT_AUTO) begin
         elig1 = elig1 | ((rt_cfg_r[`CNR_F_TUNE_LSB +: 2] == 2'h0)
                 & ~rt_cfg_r[`CNR_F_F1EN_BIT]);
         elig2 = elig2 | ((rt_cfg_r[`CNR_F_F2SEL_LSB +: 2] == 2'h0)
                 & ~rt_cfg_r[`CNR_F_F2EN_BIT]);
      end
      pick1 = elig1 & (~elig2 | (abs_diff(det, freq_r[0]) <= abs_diff(det, freq_r[1])));
      fire  = osc_in.valid && (osc_in.level > det_level_r)
              && (mode == RT_CHANGE || mode == RT_AUTO)
              && (det > `CNR_MIN_HZ)
              && (elig1 || elig2);
   end

   // Retune configuration; automatic mode enables the filter it sets
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         rt_cfg_r    <= `CNR_RST_RTCFG;
         det_level_r <= `CNR_RST_LEVEL;
      end else begin
         if (apb_wr && hit && wa == `CNR_A_RETUNE_CFG)
            rt_cfg_r <= pwdata_in[7:0];
         if (fire && mode == RT_AUTO) begin
            if (pick1)
               rt_cfg_r[`CNR_F_F1EN_BIT] <= 1'b1;
            else
               rt_cfg_r[`CNR_F_F2EN_BIT] <= 1'b1;
         end
         if (apb_wr && hit && wa == `CNR_A_DET_LEVEL)
            det_level_r <= pwdata_in[15:0];
      end
   end

   // Filter frequencies; a retune overrides a same-cycle software write
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         freq_r <= {5{`CNR_RST_FREQ}};
      end else begin
         for (int i = 0; i < 5; i++) begin
            if (apb_wr && hit && wa == 8'(`CNR_A_FILT1 + 4 * i))
               freq_r[i] <= pwdata_in[15:0];
         end
         if (fire) begin
            if (pick1)
               freq_r[0] <= det;
            else
               freq_r[1] <= det;
         end
      end
   end

   // Warning window and operation count
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         warn_cnt_r <= 32'h00000000;
         warn_r     <= 1'b0;
         rt_count_r <= 16'h0000;
      end else if (fire) begin
         warn_cnt_r <= WARN_CYCLES;
         warn_r     <= 1'b1;
         rt_count_r <= rt_count_r + 16'h0001;
      end else if (warn_cnt_r != 32'h00000000) begin
         warn_cnt_r <= warn_cnt_r - 32'h00000001;
         if (warn_cnt_r == 32'h00000001)
            warn_r <= 1'b0;
      end
   end

   // Non-volatile commit pacing
   assign nv_due = nv_dirty_r && (64'(nv_timer_r) >= NV_CYCLES);

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         nv_timer_r  <= 40'h0000000000;
         nv_dirty_r  <= 1'b0;
         nv_commit_r <= 1'b0;
         nv_f1_r     <= `CNR_RST_FREQ;
         nv_f2_r     <= `CNR_RST_FREQ;
      end else begin
         nv_commit_r <= nv_due;
         if (nv_due) begin
            nv_timer_r <= 40'h0000000000;
            nv_f1_r    <= freq_r[0];
            nv_f2_r    <= freq_r[1];
         end else if (64'(nv_timer_r) < NV_CYCLES) begin
            nv_timer_r <= nv_timer_r + 40'h0000000001;
         end
         if (fire)
            nv_dirty_r <= 1'b1;
         else if (nv_due)
            nv_dirty_r <= 1'b0;
      end
   end

   // Notch staging: wait for lock, then the hold time set by the live frequency
   assign wait_lim = (!notch_r.enable || notch_r.freq_chz >= `CNR_FAST_MIN_CHZ)
                     ? FAST_CYCLES : SLOW_CYCLES;
   assign apply    = (nstate_r == NS_WAIT) && !motion_busy_in
                     && (wait_cnt_r + 32'h00000001 >= wait_lim);

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         notch_cfg_r  <= `CNR_RST_NOTCH;
         notch_pend_r <= 1'b0;
      end else if (apb_wr && hit && wa == `CNR_A_NOTCH_CFG) begin
         notch_cfg_r  <= pwdata_in[11:0];
         notch_pend_r <= 1'b1;
      end else if (apply) begin
         notch_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         nstate_r   <= NS_IDLE;
         wait_cnt_r <= 32'h00000000;
      end else begin
         unique case (nstate_r)
            NS_IDLE: begin
               wait_cnt_r <= 32'h00000000;
               if (notch_pend_r)
                  nstate_r <= NS_WAIT;
            end
            NS_WAIT: begin
               if (motion_busy_in || (apb_wr && hit && wa == `CNR_A_NOTCH_CFG))
                  wait_cnt_r <= 32'h00000000;
               else if (apply)
                  nstate_r <= NS_IDLE;
               else
                  wait_cnt_r <= wait_cnt_r + 32'h00000001;
            end
         endcase
      end
   end

   // Whole notch setting changes in one edge
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         notch_r <= '0;
      end else if (apply) begin
         notch_r.code       <= notch_cfg_r[`CNR_F_FREQ_LSB +: 8];
         notch_r.depth_code <= notch_cfg_r[`CNR_F_DEPTH_LSB +: 4];
         notch_r.freq_chz   <= freq_chz(notch_cfg_r[`CNR_F_FREQ_LSB +: 8]);
         notch_r.depth_cdb  <= depth_cdb(notch_cfg_r[`CNR_F_DEPTH_LSB +: 4]);
         notch_r.enable     <= freq_chz(notch_cfg_r[`CNR_F_FREQ_LSB +: 8]) != 18'd0;
      end
   end

   assign prdata_out         = prdata_r;
   assign pready_out         = 1'b1;
   assign pslverr_out        = pslverr_r & psel_in & penable_in;
   assign notch_out          = notch_r;
   assign res_freq_out       = freq_r;
   assign res_en_out         = {rt_cfg_r[`CNR_F_F2EN_BIT], rt_cfg_r[`CNR_F_F1EN_BIT]};
   assign retune_warning_out = warn_r;
   assign retune_count_out   = rt_count_r;
   assign nv_commit_out      = nv_commit_r;
   assign nv_freq1_out       = nv_f1_r;
   assign nv_freq2_out       = nv_f2_r;

endmodule
`default_nettype wire

// file: verification/cnr_servo_model.sv
// Model of the oscillation detector and motion state feeding cnr_core
// The bench calls shake and hold by hierarchical reference
`timescale 1ns/100ps
`default_nettype none
module cnr_servo_model
   import cnr_pkg::*;
(
   // Clock
   input  wire logic clock_in,
   // Towards the block
   output cnr_osc_t  osc_out,
   output logic      busy_out
);
   initial begin
      osc_out = '0;
      busy_out = 1'b0;
   end
   // Positioning state, changed on the clock edge
   task automatic hold(input logic b);
      busy_out <= b;
   endtask
   // One-cycle detection; the fields are scrambled outside it
   task automatic shake(input logic [15:0] f, input logic [15:0] l);
      @(posedge clock_in);
      osc_out <= '{1'b1, l, f};
      @(posedge clock_in);
      osc_out <= '{1'b0, ~l, ~f};
   endtask
endmodule
`default_nettype wire

// file: verification/cnr_core_assertions.sv
// Port checker of cnr_core
// Bound into cnr_core; one clock domain
`timescale 1ns/100ps
`default_nettype none
module cnr_core_assertions
   import cnr_pkg::*;
#(
   parameter int unsigned     WARN_CYCLES = 20,
   parameter longint unsigned NV_CYCLES   = 50,
   parameter int unsigned     FAST_CYCLES = 10,
   parameter int unsigned     SLOW_CYCLES = 30
) (
   input wire logic             clock_in,
   input wire logic             sys_rst_in,
   input wire logic             psel_in,
   input wire logic             penable_in,
   input wire logic             pwrite_in,
   input wire logic [31:0]      paddr_in,
   input wire logic             pslverr_out,
   input wire logic             motion_busy_in,
   input wire cnr_osc_t         osc_in,
   input wire cnr_notch_t       notch_out,
   input wire logic [4:0][15:0] res_freq_out,
   input wire logic             retune_warning_out,
   input wire logic [15:0]      retune_count_out,
   input wire logic             nv_commit_out
);
   logic [15:0] cnt_q_r;
   logic [31:0] run_r;
   logic [39:0] age_r;
   logic [31:0] idle_r;
   // Warning run since last retune, cycles since commit, quiet motion run
   always_ff @(posedge clock_in) begin
      cnt_q_r <= retune_count_out;
      if (sys_rst_in) begin
         run_r <= '0;
         age_r <= '0;
         idle_r <= '0;
      end else begin
         run_r <= (retune_count_out != cnt_q_r) ? 32'h1 :
                  retune_warning_out ? run_r + 32'h1 : 32'h0;
         age_r <= nv_commit_out ? 40'h1 : age_r + 40'h1;
         idle_r <= motion_busy_in ? 32'h0 : idle_r + 32'h1;
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   property p_cnt_step;
      $changed(retune_count_out) |-> retune_count_out == $past(retune_count_out) + 16'h1;
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("count step wrong");
   property p_cnt_cause;
      $changed(retune_count_out) |-> $past(osc_in.valid && osc_in.freq_hz > 16'd100);
   endproperty
   a_cnt_cause: assert property (p_cnt_cause) else $error("retune without cause");
   property p_cnt_warn;
      $changed(retune_count_out) |-> retune_warning_out;
   endproperty
   a_cnt_warn: assert property (p_cnt_warn) else $error("retune without warning");
   property p_warn_end;
      $fell(retune_warning_out) |-> run_r == WARN_CYCLES;
   endproperty
   a_warn_end: assert property (p_warn_end) else $error("warning too short");
   property p_warn_max;
      retune_warning_out |-> run_r <= WARN_CYCLES;
   endproperty
   a_warn_max: assert property (p_warn_max) else $error("warning too long");
   property p_nv_pulse;
      nv_commit_out |=> !nv_commit_out;
   endproperty
   a_nv_pulse: assert property (p_nv_pulse) else $error("commit pulse too long");
   property p_nv_gap;
      nv_commit_out |-> age_r >= NV_CYCLES;
   endproperty
   a_nv_gap: assert property (p_nv_gap) else $error("commits too close");
   property p_f345;
      $changed(res_freq_out[4:2]) |->
         $past(psel_in && penable_in && pwrite_in && paddr_in inside {32'h18, 32'h1C, 32'h20});
   endproperty
   a_f345: assert property (p_f345) else $error("filter 3 to 5 altered");
   property p_notch_wait;
      $changed(notch_out) |-> idle_r >= FAST_CYCLES;
   endproperty
   a_notch_wait: assert property (p_notch_wait) else $error("notch applied early");
   property p_notch_en;
      notch_out.enable |-> notch_out.code != 8'h00 && notch_out.code <= 8'h7F;
   endproperty
   a_notch_en: assert property (p_notch_en) else $error("notch on for bad code");
   property p_slverr;
      psel_in && penable_in && paddr_in > 32'h24 |-> pslverr_out;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access accepted");
   c_retune: cover property ($rose(retune_warning_out));
   c_commit: cover property (nv_commit_out);
   c_notch: cover property ($changed(notch_out));
endmodule
bind cnr_core cnr_core_assertions #(
   .WARN_CYCLES(WARN_CYCLES),
   .NV_CYCLES(NV_CYCLES),
   .FAST_CYCLES(FAST_CYCLES),
   .SLOW_CYCLES(SLOW_CYCLES)
) u_chk (
   .clock_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pslverr_out,
   .motion_busy_in, .osc_in, .notch_out, .res_freq_out, .retune_warning_out,
   .retune_count_out, .nv_commit_out
);
`default_nettype wire

// file: verification/command_notch_and_resonance_retune_test.sv
// Self-checking bench of cnr_core over APB with a servo model
// Uses shortened counts: warning 20, commit 50, waits 10 and 30
`timescale 1ns/100ps
`default_nettype none
`include "cnr_defs.svh"
module command_notch_and_resonance_retune_test import cnr_pkg::*;;
   localparam int W = 20, NV = 50, FA = 10, SL = 30;
   typedef struct packed {
      logic [7:0] c; logic [3:0] d; logic en; logic [17:0] hz; logic [9:0] db;
   } cnr_nc_t;
   cnr_nc_t tab [6] = '{
      '{8'h01, 4'hF, 1'b1, 18'h30D40, 10'h006}, '{8'h7F, 4'h0, 1'b1, 18'h00070, 10'h190},
      '{8'h5F, 4'h1, 1'b1, 18'h001C2, 10'h0F1}, '{8'h16, 4'h8, 1'b1, 18'h02710, 10'h03C},
      '{8'h05, 4'hA, 1'b0, 18'h00000, 10'h029}, '{8'h00, 4'h5, 1'b0, 18'h00000, 10'h065}};
   logic clock_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, r;
   logic pready, pslverr, busy, warn, nvc, e;
   cnr_osc_t osc;
   cnr_notch_t notch;
   logic [4:0][15:0] res;
   logic [1:0] res_en;
   logic [15:0] cnt, nv1, nv2;
   int n_mismatch = 0, n_tests = 0, n, x;
   always #4 clock_in = ~clock_in;
   cnr_core #(.WARN_CYCLES(W), .NV_CYCLES(NV), .FAST_CYCLES(FA), .SLOW_CYCLES(SL)) DUT (
      .clock_in, .sys_rst_in, .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .motion_busy_in(busy), .osc_in(osc), .notch_out(notch),
      .res_freq_out(res), .res_en_out(res_en), .retune_warning_out(warn),
      .retune_count_out(cnt), .nv_commit_out(nvc), .nv_freq1_out(nv1), .nv_freq2_out(nv2));
   cnr_servo_model M (.clock_in, .osc_out(osc), .busy_out(busy));
   task automatic chk(input logic [31:0] g, input logic [31:0] v);
      n_tests++;
      if (g !== v) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, g, v);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clock_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      @(posedge clock_in);
      while (pready !== 1'b1) @(posedge clock_in);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] v);
      apb(1'b0, a, '0);
      chk(r, v);
   endtask
   task automatic ev(input logic [15:0] f, input logic [15:0] l, input logic [31:0] v1,
                     input logic [31:0] v2, input logic [31:0] vc);
      M.shake(f, l);
      @(posedge clock_in);
      chk(32'(res[0]), v1);
      chk(32'(res[1]), v2);
      chk(32'(cnt), vc);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      rd(`CNR_A_NOTCH_CFG, 32'h0);
      rd(`CNR_A_RETUNE_CFG, 32'h0);
      apb(1'b0, 32'h28, 32'h0);
      chk(32'(e), 32'h1);
      apb(1'b1, 32'h02, 32'h5);
      chk(32'(e), 32'h1);
      foreach (tab[i]) begin
         M.hold(1'b1);
         apb(1'b1, `CNR_A_NOTCH_CFG, {20'h0, tab[i].d, tab[i].c});
         repeat (20) @(posedge clock_in);
         chk(32'(notch.code), 32'(i ? tab[i - 1].c : 8'h00));
         M.hold(1'b0);
         n = 0;
         while (notch.code !== tab[i].c && n < 100) begin
            @(posedge clock_in);
            n++;
         end
         x = (i > 0 && tab[i - 1].en && tab[i - 1].hz < 18'd450) ? SL : FA;
         chk(32'(n >= x && n <= x + 2), 32'h1);
         chk(32'({notch.enable, notch.freq_chz, notch.depth_cdb}),
             32'({tab[i].en, tab[i].hz, tab[i].db}));
         rd(`CNR_A_NOTCH_ACT, {19'h0, tab[i].en, tab[i].d, tab[i].c});
      end
      for (int k = 0; k < 5; k++)
         apb(1'b1, 32'h10 + 32'(4 * k), 32'(1000 * (k + 1)));
      apb(1'b1, `CNR_A_DET_LEVEL, 32'd100);
      apb(1'b1, `CNR_A_RETUNE_CFG, 32'hC1);
      ev(1300, 101, 1300, 2000, 1);
      chk(32'(warn), 32'h1);
      ev(1500, 100, 1300, 2000, 1);
      ev(1650, 200, 1650, 2000, 2);
      ev(1900, 200, 1650, 1900, 3);
      apb(1'b1, `CNR_A_RETUNE_CFG, 32'hC0);
      ev(1900, 200, 1650, 1900, 3);
      apb(1'b1, `CNR_A_RETUNE_CFG, 32'h02);
      ev(3000, 200, 1650, 3000, 4);
      chk(32'(res_en), 32'h2);
      ev(100, 200, 1650, 3000, 4);
      ev(101, 200, 101, 3000, 5);
      apb(1'b1, `CNR_A_RETUNE_CFG, 32'h16);
      ev(150, 200, 101, 3000, 5);
      apb(1'b1, `CNR_A_RETUNE_CFG, 32'h03);
      ev(150, 200, 101, 3000, 5);
      for (int k = 2; k < 5; k++)
         chk(32'(res[k]), 32'(1000 * (k + 1)));
      apb(1'b0, `CNR_A_STATUS, 32'h0);
      chk(32'(r[15:0]), 32'h5);
      n = 0;
      while (!(nvc === 1'b1 && nv1 === 16'd101 && nv2 === 16'd3000) && n < 200) begin
         @(posedge clock_in);
         n++;
      end
      chk(32'(n < 200), 32'h1);
      sys_rst_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      rd(`CNR_A_STATUS, 32'h0);
      rd(`CNR_A_FILT1, 32'h0);
      final_report;
   end
   initial begin
      repeat (20000) @(posedge clock_in);
      n_mismatch++;
      final_report;
   end
endmodule
`default_nettype wire
